// File: core/timer16_pkg.sv
// shared constants for the 16-bit timer capture / interrupt register slice
package timer16_pkg;
   // address windows: port instructions reach 0x00..0x3F, data space adds 0x20
   localparam logic [7:0] IO_LAST_OFFSET = 8'h3F;
   localparam logic [7:0] DATA_SPACE_BIAS = 8'h20;
   localparam logic [7:0] DATA_SPACE_LAST = 8'h5F;
   // register offsets in the port window
   localparam logic [7:0] CAPTURE_LOW_OFS = 8'h26;
   localparam logic [7:0] CAPTURE_HIGH_OFS = 8'h27;
   localparam logic [7:0] COMPARE_B_LOW_OFS = 8'h28;
   localparam logic [7:0] COMPARE_B_HIGH_OFS = 8'h29;
   localparam logic [7:0] COMPARE_A_LOW_OFS = 8'h2A;
   localparam logic [7:0] COMPARE_A_HIGH_OFS = 8'h2B;
   localparam logic [7:0] COUNTER_LOW_OFS = 8'h2C;
   localparam logic [7:0] COUNTER_HIGH_OFS = 8'h2D;
   localparam logic [7:0] IRQ_FLAGS_OFS = 8'h38;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h39;
   // bit positions shared by the mask and the flag register
   localparam int CAPTURE_BIT = 5;
   localparam int COMPARE_A_BIT = 4;
   localparam int COMPARE_B_BIT = 3;
   localparam int OVERFLOW_BIT = 2;
   // bits of the shared registers that this timer owns
   localparam logic [7:0] TIMER_BITS = 8'h3C;
   // reset values
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   // counter ceiling for overflow in normal and clear-on-compare modes
   localparam logic [15:0] COUNTER_MAX = 16'hFFFF;
endpackage

// File: core/capture_trigger.sv
`timescale 1ns/1ps
`default_nettype none
// synchronises the capture pin and the comparator output, picks one and
// turns the selected edge into a one-cycle capture event
module capture_trigger
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic pin,
   input wire logic comparator,
   input wire logic use_comparator,
   input wire logic rising,
   input wire logic connected,
   output logic event_pulse
);
   import timer16_pkg::*;

   logic [1:0] pin_sync; // two-stage synchroniser for the pin
   logic [1:0] comp_sync; // two-stage synchroniser for the comparator
   logic level; // selected, synchronised trigger level
   logic level_prev; // one cycle older copy for edge detection

   // both sources are asynchronous to REF_CLK, so each gets two flops
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pin_sync <= 2'h0;
         comp_sync <= 2'h0;
      end
      else
      begin
         pin_sync <= {pin_sync[0], pin};
         comp_sync <= {comp_sync[0], comparator};
      end
   end

   // source select happens after the synchronisers, never before
   assign level = use_comparator ? comp_sync[1] : pin_sync[1];

   // history flop; a source switch may look like an edge, so software
   // should clear the capture flag after changing the source
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         level_prev <= 1'b0;
      else
         level_prev <= level;
   end

   // rising when selected, falling otherwise; gated off while disconnected
   always_comb
   begin
      if (!connected)
         event_pulse = 1'b0;
      else if (rising)
         event_pulse = level && !level_prev;
      else
         event_pulse = !level && level_prev;
   end
endmodule
`default_nettype wire

// File: core/timer16_capture_irq_regs.sv
// Behaviour
// - ports 0x00-0x3F, data space adds 0x20
// - capture event copies counter into capture register
// - comparator output may replace capture pin
// - capture register can serve as counter top
// - 16-bit accesses pass through temp high latch
// - one temp latch shared by all 16-bit registers
// - capture irq needs enable5, global, flag
// - compare-A irq needs enable4, global, flag
// - compare-B irq needs enable3, global, flag
// - overflow irq needs enable2, global, flag
// - capture event sets capture flag bit 5
// - capture-as-top modes set flag at top
// - flags clear when their vector executes
// - writing one clears flag, zero keeps
// - compare-A flag set after counter matches
// - compare-B flag set after counter matches
// - force-compare strobes never set match flags
// - overflow flag on overflow in normal/CLEAR_ON_COMPARE_MODE
// - edge select: zero falling, one rising
// - capture input disconnected while capture is top
`timescale 1ns/1ps
`default_nettype none
module timer16_capture_irq_regs
#(
   // waveform modes that use the capture register as top, one bit per mode
   parameter logic [15:0] CAPTURE_TOP_MODES = 16'h5500,
   // modes whose overflow fires at counter max (normal, clear-on-compare)
   parameter logic [15:0] OVERFLOW_AT_MAX_MODES = 16'h1011
)
(
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic IO_SPACE,
   input wire logic [7:0] ADDR,
   input wire logic WR_EN,
   input wire logic RD_EN,
   input wire logic [7:0] WDATA,
   output logic [7:0] RDATA,
   output logic READ_HIT,
   input wire logic [15:0] COUNTER_VALUE,
   input wire logic TIMER_TICK,
   input wire logic COUNTER_AT_TOP,
   input wire logic [15:0] COMPARE_A_VALUE,
   input wire logic [7:0] COMPARE_B_VALUE_LOW,
   input wire logic [3:0] WAVEFORM_MODE_SELECT,
   input wire logic CAPTURE_EDGE_SELECT,
   input wire logic CAPTURE_FROM_COMPARATOR,
   input wire logic CAPTURE_INPUT_PIN,
   input wire logic COMPARATOR_OUT,
   input wire logic FORCE_COMPARE_A_STROBE,
   input wire logic FORCE_COMPARE_B_STROBE,
   input wire logic GLOBAL_IRQ_ENABLE,
   input wire logic ACK_CAPTURE,
   input wire logic ACK_COMPARE_A,
   input wire logic ACK_COMPARE_B,
   input wire logic ACK_OVERFLOW,
   output logic IRQ_CAPTURE,
   output logic IRQ_COMPARE_A,
   output logic IRQ_COMPARE_B,
   output logic IRQ_OVERFLOW,
   output logic [15:0] CAPTURE_VALUE,
   output logic CAPTURE_IS_TOP,
   output logic [7:0] COMPARE_B_VALUE_HIGH,
   output logic [7:0] TEMP_HIGH
);
   import timer16_pkg::*;

   // normal mode (0) counts free and can never take the capture value as top
   if (CAPTURE_TOP_MODES[0])
   begin
      $error("mode 0 cannot use the capture register as top");
   end

   // folds both address spaces onto one port offset; msb flags a hit
   function automatic logic [8:0] map_offset(input logic io,
                                             input logic [7:0] a);
      logic [8:0] r;
      r = 9'h000;
      if (io)
      begin
         if (a <= IO_LAST_OFFSET)
            r = {1'b1, a};
      end
      else if (a >= DATA_SPACE_BIAS && a <= DATA_SPACE_LAST)
         r = {1'b1, 8'(a - DATA_SPACE_BIAS)};
      return r;
   endfunction

   // a compare match counts only on a timer clock tick
   function automatic logic match(input logic tick,
                                  input logic [15:0] count,
                                  input logic [15:0] value);
      return tick && (count == value);
   endfunction

   logic [8:0] mapped; // hit flag and folded offset
   logic [7:0] offset; // offset within the port window
   logic in_window; // address falls in one of the windows
   logic [7:0] capture_value; // low byte of the capture register
   logic [15:0] capture_reg; // capture register contents
   logic [7:0] temp; // shared high byte latch
   logic [7:0] compare_b_high; // upper byte of compare value B
   logic [7:0] mask; // interrupt enables, owned bits only
   logic [7:0] flags; // interrupt flags, owned bits only
   logic [7:0] set_vec; // hardware events this cycle
   logic [7:0] clr_vec; // software and acknowledge clears this cycle
   logic capture_event; // qualified edge on the capture source
   logic capture_is_top; // current mode uses capture as top
   logic overflow_at_max; // current mode overflows at counter max
   logic wr_flags; // write strobe to the flag register
   logic wr_mask; // write strobe to the mask register

   assign capture_value = capture_reg[7:0];
   assign mapped = map_offset(IO_SPACE, ADDR);
   assign in_window = mapped[8];
   assign offset = mapped[7:0];
   assign wr_flags = WR_EN && in_window && offset == IRQ_FLAGS_OFS;
   assign wr_mask = WR_EN && in_window && offset == IRQ_MASK_OFS;

   // mode lookups; the full mode table lives with the counter unit
   assign capture_is_top = CAPTURE_TOP_MODES[WAVEFORM_MODE_SELECT];
   assign overflow_at_max = OVERFLOW_AT_MAX_MODES[WAVEFORM_MODE_SELECT];

   // edge detection and source choice; pin is cut off while capture is top
   capture_trigger trigger
   (
      .clk(REF_CLK),
      .rstn(RSTN),
      .pin(CAPTURE_INPUT_PIN),
      .comparator(COMPARATOR_OUT),
      .use_comparator(CAPTURE_FROM_COMPARATOR),
      .rising(CAPTURE_EDGE_SELECT),
      .connected(!capture_is_top),
      .event_pulse(capture_event)
   );

   // capture register: an event wins over a cpu write in the same cycle,
   // since losing a timestamp is worse than losing a top reprogram
   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
         capture_reg <= WORD_RESET;
      else if (capture_event)
         capture_reg <= COUNTER_VALUE;
      else if (WR_EN && in_window && offset == CAPTURE_LOW_OFS)
         capture_reg <= {temp, WDATA};
   end

   // temp latch: any high byte write parks the byte; low byte reads of
   // the capture and counter registers snapshot their upper half
   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
         temp <= BYTE_RESET;
      else if (WR_EN && in_window &&
               (offset == CAPTURE_HIGH_OFS || offset == COMPARE_B_HIGH_OFS ||
                offset == COMPARE_A_HIGH_OFS || offset == COUNTER_HIGH_OFS))
         temp <= WDATA;
      else if (RD_EN && in_window && offset == CAPTURE_LOW_OFS)
         temp <= capture_reg[15:8];
      else if (RD_EN && in_window && offset == COUNTER_LOW_OFS)
         temp <= COUNTER_VALUE[15:8];
   end

   // compare B upper byte commits from temp when the low byte is written
   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
         compare_b_high <= BYTE_RESET;
      else if (WR_EN && in_window && offset == COMPARE_B_LOW_OFS)
         compare_b_high <= temp;
   end

   // mask register keeps only this timer's bits
   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
         mask <= BYTE_RESET;
      else if (wr_mask)
         mask <= WDATA & TIMER_BITS;
   end

   // hardware set sources; force strobes are deliberately not inputs here
   always_comb
   begin
      set_vec = BYTE_RESET;
      if (capture_is_top)
         set_vec[CAPTURE_BIT] = TIMER_TICK && COUNTER_AT_TOP;
      else
         set_vec[CAPTURE_BIT] = capture_event;
      // the flag rises on the edge that ends the matching timer cycle
      set_vec[COMPARE_A_BIT] =
         match(TIMER_TICK, COUNTER_VALUE, COMPARE_A_VALUE);
      set_vec[COMPARE_B_BIT] = match(TIMER_TICK, COUNTER_VALUE,
         {compare_b_high, COMPARE_B_VALUE_LOW});
      if (overflow_at_max)
         set_vec[OVERFLOW_BIT] =
            TIMER_TICK && COUNTER_VALUE == COUNTER_MAX;
      else
         set_vec[OVERFLOW_BIT] = TIMER_TICK && COUNTER_AT_TOP;
   end

   // clear sources: write-one-to-clear and vector acknowledges
   always_comb
   begin
      clr_vec = wr_flags ? WDATA : BYTE_RESET;
      if (ACK_CAPTURE)
         clr_vec[CAPTURE_BIT] = 1'b1;
      if (ACK_COMPARE_A)
         clr_vec[COMPARE_A_BIT] = 1'b1;
      if (ACK_COMPARE_B)
         clr_vec[COMPARE_B_BIT] = 1'b1;
      if (ACK_OVERFLOW)
         clr_vec[OVERFLOW_BIT] = 1'b1;
   end

   // flags: a set in the same cycle as a clear survives
   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
         flags <= BYTE_RESET;
      else
         flags <= ((flags & ~clr_vec) | set_vec) & TIMER_BITS;
   end

   // interrupt requests, combinational so they drop with the flag
   assign IRQ_CAPTURE = GLOBAL_IRQ_ENABLE && mask[CAPTURE_BIT] &&
                        flags[CAPTURE_BIT];
   assign IRQ_COMPARE_A = GLOBAL_IRQ_ENABLE && mask[COMPARE_A_BIT] &&
                          flags[COMPARE_A_BIT];
   assign IRQ_COMPARE_B = GLOBAL_IRQ_ENABLE && mask[COMPARE_B_BIT] &&
                          flags[COMPARE_B_BIT];
   assign IRQ_OVERFLOW = GLOBAL_IRQ_ENABLE && mask[OVERFLOW_BIT] &&
                         flags[OVERFLOW_BIT];

   // read path, registered; other offsets answer zero with no hit
   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         RDATA <= BYTE_RESET;
         READ_HIT <= 1'b0;
      end
      else if (RD_EN && in_window)
      begin
         READ_HIT <= 1'b1;
         unique case (offset)
            CAPTURE_LOW_OFS: RDATA <= capture_value;
            CAPTURE_HIGH_OFS: RDATA <= temp;
            COMPARE_B_HIGH_OFS: RDATA <= compare_b_high;
            IRQ_FLAGS_OFS: RDATA <= flags;
            IRQ_MASK_OFS: RDATA <= mask;
            default:
            begin
               RDATA <= BYTE_RESET;
               READ_HIT <= 1'b0;
            end
         endcase
      end
      else
      begin
         RDATA <= BYTE_RESET;
         READ_HIT <= 1'b0;
      end
   end

   assign CAPTURE_VALUE = capture_reg;
   assign CAPTURE_IS_TOP = capture_is_top;
   assign COMPARE_B_VALUE_HIGH = compare_b_high;
   assign TEMP_HIGH = temp;

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RSTN);

   sequence high_write_s;
      WR_EN && in_window && offset == CAPTURE_HIGH_OFS;
   endsequence
   sequence low_write_s;
      WR_EN && in_window && offset == CAPTURE_LOW_OFS && !capture_event;
   endsequence

   a_capture_loads_counter: assert property (capture_event |=>
      capture_reg == $past(COUNTER_VALUE))
      else $error("capture did not load counter");
   a_capture_sets_flag: assert property (
      capture_event && !capture_is_top |=> flags[CAPTURE_BIT])
      else $error("capture event did not set flag");
   a_capture_pin_cut: assert property (capture_is_top |->
      !capture_event)
      else $error("capture event while capture is top");
   a_atomic_capture_write: assert property (
      high_write_s ##1 low_write_s
      |=> capture_reg == {$past(WDATA, 2), $past(WDATA)})
      else $error("split write not atomic");
   a_low_read_latch: assert property (RD_EN && in_window &&
      offset == CAPTURE_LOW_OFS && !WR_EN |=> temp == $past(capture_reg[15:8]))
      else $error("temp not loaded on low read");
   a_capture_irq_gate: assert property (IRQ_CAPTURE |->
      GLOBAL_IRQ_ENABLE && mask[5] && flags[5])
      else $error("capture irq without cause");
   a_compare_a_flag: assert property (TIMER_TICK &&
      COUNTER_VALUE == COMPARE_A_VALUE |=> flags[4])
      else $error("compare A flag missed");
   a_compare_b_flag: assert property (
      TIMER_TICK && COUNTER_VALUE == {compare_b_high, COMPARE_B_VALUE_LOW}
      |=> flags[3])
      else $error("compare B flag missed");
   a_force_no_flag: assert property (
      FORCE_COMPARE_A_STROBE && !flags[4] && !set_vec[4] |=> !flags[4])
      else $error("force strobe set compare flag");
   a_overflow_gate: assert property (IRQ_OVERFLOW |->
      $past(set_vec[2]) || $past(flags[2]))
      else $error("overflow irq without flag history");
   a_w1c_clear: assert property (wr_flags && WDATA[2] && !set_vec[2]
      |=> !flags[2])
      else $error("write one did not clear");
   a_ack_clears: assert property (ACK_COMPARE_A && !set_vec[4]
      |=> !flags[4] && !IRQ_COMPARE_A)
      else $error("ack did not clear flag");
   a_unowned_zero: assert property ((flags & ~TIMER_BITS) == 8'h00 &&
      (mask & ~TIMER_BITS) == 8'h00)
      else $error("unowned bit set");
endmodule
`default_nettype wire

// File: verif/irq_partner.sv
`timescale 1ns/1ps
`default_nettype none
// interrupt side of the cpu: enters one pending vector after a wait
module irq_partner
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [3:0] irq,
   input wire logic [3:0] wait_cycles,
   output logic [3:0] ack
);
   logic [3:0] waited; // cycles spent on the current request
   // lowest request wins; one ack pulse per vector entry
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         waited <= 4'h0;
         ack <= 4'h0;
      end
      else if (ack != 4'h0 || irq == 4'h0)
      begin
         // back off a cycle so a request still high is not taken twice
         waited <= 4'h0;
         ack <= 4'h0;
      end
      else if (waited < wait_cycles)
         waited <= waited + 4'h1; // slow answer
      else
         ack <= irq & (~irq + 4'h1);
   end
endmodule
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   // bus side
   logic clk, rstn, io_space, wr_en, rd_en, read_hit, rd_seen;
   logic [7:0] addr, wdata, rdata, cmp_b_low, cmp_b_high, temp_high;
   // timer side
   logic [15:0] cnt_val, cmp_a, cap_val, cv;
   logic tick, at_top, edge_sel, from_cmp, pin, cmp_out, force_a, force_b;
   logic gie, cap_top, src, es;
   logic [3:0] mode, ack, irq, slow;
   int failures = 0;
   int cmp_count = 0;
   int seed = 32'hf6c9_56cd;
   logic [16:0] notes[$]; // expected reads: offset, hit, data
   logic [16:0] note;
   logic [7:0] owned[5] = '{8'h26, 8'h27, 8'h29, 8'h38, 8'h39};
   timer16_capture_irq_regs u_timer16_capture_irq_regs
   (
      .REF_CLK(clk),
      .RSTN(rstn),
      .IO_SPACE(io_space),
      .ADDR(addr),
      .WR_EN(wr_en),
      .RD_EN(rd_en),
      .WDATA(wdata),
      .RDATA(rdata),
      .READ_HIT(read_hit),
      .COUNTER_VALUE(cnt_val),
      .TIMER_TICK(tick),
      .COUNTER_AT_TOP(at_top),
      .COMPARE_A_VALUE(cmp_a),
      .COMPARE_B_VALUE_LOW(cmp_b_low),
      .WAVEFORM_MODE_SELECT(mode),
      .CAPTURE_EDGE_SELECT(edge_sel),
      .CAPTURE_FROM_COMPARATOR(from_cmp),
      .CAPTURE_INPUT_PIN(pin),
      .COMPARATOR_OUT(cmp_out),
      .FORCE_COMPARE_A_STROBE(force_a),
      .FORCE_COMPARE_B_STROBE(force_b),
      .GLOBAL_IRQ_ENABLE(gie),
      .ACK_CAPTURE(ack[0]),
      .ACK_COMPARE_A(ack[1]),
      .ACK_COMPARE_B(ack[2]),
      .ACK_OVERFLOW(ack[3]),
      .IRQ_CAPTURE(irq[0]),
      .IRQ_COMPARE_A(irq[1]),
      .IRQ_COMPARE_B(irq[2]),
      .IRQ_OVERFLOW(irq[3]),
      .CAPTURE_VALUE(cap_val),
      .CAPTURE_IS_TOP(cap_top),
      .COMPARE_B_VALUE_HIGH(cmp_b_high),
      .TEMP_HIGH(temp_high)
   );
   irq_partner u_irq_partner
   (
      .clk(clk),
      .rstn(rstn),
      .irq(irq),
      .wait_cycles(slow),
      .ack(ack)
   );
   // compare and count; a mismatch is printed at once
   task automatic chk(input string what, input logic [16:0] exp,
      input logic [16:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one strobe; port or data-space address picked at random each time
   task automatic acc(input logic w, input logic [7:0] ofs,
      input logic [7:0] d);
      logic ds;
      ds = 1'($random(seed));
      @(posedge clk);
      io_space <= ds;
      addr <= ds ? ofs : ofs + 8'h20;
      wr_en <= w;
      rd_en <= !w;
      wdata <= d;
      @(posedge clk);
      wr_en <= 1'b0;
      rd_en <= 1'b0;
   endtask
   // a read leaves its expected answer for the monitor
   task automatic rd(input logic [7:0] ofs, input logic [8:0] exp);
      notes.push_back({ofs, exp});
      acc(1'b0, ofs, 8'h00);
   endtask
   // tick for one cycle
   task automatic pulse();
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
   endtask
   // selected line gets v, the other the inverse to catch a wrong source
   task automatic drive(input logic v);
      pin <= src ? ~v : v;
      cmp_out <= src ? v : ~v;
   endtask
   task automatic results();
      $display("compares %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // read data stands for the one cycle after the strobe edge
   always @(posedge clk)
      rd_seen <= rd_en;
   always @(negedge clk)
      if (rd_seen)
      begin
         note = notes.pop_front();
         chk("read", note, {note[16:9], read_hit, rdata});
      end
   // the whole sequence needs well under a thousand cycles
   initial
   begin
      #100000;
      failures++;
      results();
   end
   initial
   begin
      {rstn, io_space, wr_en, rd_en, tick, at_top, edge_sel} = 7'h00;
      {from_cmp, pin, cmp_out, force_a, force_b, gie, src} = 7'h00;
      {addr, wdata, cmp_b_low, mode, slow} = 32'h0000_0000;
      {cnt_val, cmp_a} = 32'h0000_0000;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      foreach (owned[i]) rd(owned[i], 9'h100);
      rd(8'h30, 9'h000);
      // high byte parks in the shared latch, low byte commits both
      acc(1'b1, 8'h27, 8'h12);
      @(negedge clk);
      chk("temp", 17'h0_0012, {9'h000, temp_high});
      acc(1'b1, 8'h26, 8'h34);
      @(negedge clk);
      chk("capture", {1'b0, 16'h1234}, {1'b0, cap_val});
      rd(8'h26, 9'h134);
      rd(8'h27, 9'h112);
      // the latch filled for one register lands in another
      acc(1'b1, 8'h27, 8'h55);
      acc(1'b1, 8'h28, 8'h00);
      @(negedge clk);
      chk("cmp_b_high", 17'h0_0055, {9'h000, cmp_b_high});
      rd(8'h29, 9'h155);
      rd(8'h26, 9'h134);
      rd(8'h27, 9'h112);
      acc(1'b1, 8'h39, 8'hff);
      rd(8'h39, 9'h13c);
      acc(1'b1, 8'h38, 8'hff);
      rd(8'h38, 9'h100);
      // pin rising, pin falling, comparator rising
      for (int i = 0; i < 3; i++)
      begin
         src = (i == 2);
         es = (i != 1);
         @(posedge clk);
         from_cmp <= src;
         edge_sel <= es;
         drive(!es);
         repeat (6) @(posedge clk);
         acc(1'b1, 8'h38, 8'h20);
         cv = 16'($random(seed));
         cnt_val <= cv;
         drive(es);
         repeat (6) @(posedge clk);
         rd(8'h26, {1'b1, cv[7:0]});
         rd(8'h27, {1'b1, cv[15:8]});
         rd(8'h38, 9'h120);
      end
      // forced compares on a tick without a match leave the flags alone
      cmp_a <= 16'h8000 | (16'($random(seed)) & 16'h7ffe);
      cmp_b_low <= 8'($random(seed));
      cnt_val <= 16'h0000;
      acc(1'b1, 8'h38, 8'h20);
      @(posedge clk);
      {force_a, force_b, tick} <= 3'h7;
      @(posedge clk);
      {force_a, force_b, tick} <= 3'h0;
      rd(8'h38, 9'h100);
      cnt_val <= cmp_a;
      pulse();
      rd(8'h38, 9'h110);
      cnt_val <= {8'h55, cmp_b_low};
      pulse();
      rd(8'h38, 9'h118);
      acc(1'b1, 8'h38, 8'h10);
      rd(8'h38, 9'h108);
      cnt_val <= 16'hffff;
      pulse();
      rd(8'h38, 9'h10c);
      // capture as top: pin edges ignored, a top tick sets the flag
      mode <= 4'h8;
      edge_sel <= 1'b1;
      from_cmp <= 1'b0;
      cnt_val <= 16'h1234;
      pin <= 1'b1;
      @(negedge clk);
      chk("top", 17'h0_0001, {16'h0000, cap_top});
      repeat (6) @(posedge clk);
      chk("capture", {1'b0, cv}, {1'b0, cap_val});
      acc(1'b1, 8'h38, 8'h04);
      at_top <= 1'b1;
      pulse();
      rd(8'h38, 9'h12c);
      // global gate, mask gate, then a slow partner takes each vector
      slow <= 4'h6;
      mode <= 4'h0;
      at_top <= 1'b0;
      @(negedge clk);
      chk("irq", 17'h0_0000, {13'h0000, irq});
      acc(1'b1, 8'h39, 8'h00);
      gie <= 1'b1;
      repeat (2) @(negedge clk);
      chk("irq", 17'h0_0000, {13'h0000, irq});
      acc(1'b1, 8'h39, 8'h3c);
      @(negedge clk);
      chk("irq", 17'h0_000d, {13'h0000, irq});
      repeat (40) @(posedge clk);
      rd(8'h38, 9'h100);
      // a prompt partner clears a fresh compare-A request
      slow <= 4'h0;
      cnt_val <= cmp_a;
      pulse();
      @(negedge clk);
      chk("irq", 17'h0_0002, {13'h0000, irq});
      repeat (4) @(posedge clk);
      rd(8'h38, 9'h100);
      // back-to-back split write, high byte then low byte on the next edge
      @(posedge clk);
      {io_space, addr, wr_en, wdata} <= {1'b1, 8'h27, 1'b1, 8'hab};
      @(posedge clk);
      {addr, wdata} <= {8'h26, 8'hcd};
      @(posedge clk);
      wr_en <= 1'b0;
      @(negedge clk);
      chk("capture", {1'b0, 16'habcd}, {1'b0, cap_val});
      // a mid-run reset returns every owned register to zero
      pin <= 1'b0;
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      foreach (owned[i]) rd(owned[i], 9'h100);
      repeat (4) @(posedge clk);
      results();
   end
endmodule
`default_nettype wire
